// ===== src/vio_port_subsystem.sv
// interrupting i/o section: input ports, output ports, priority encoder, bus driver
`include "vio_consts.svh"
module vio_port_subsystem #(
    parameter int ADDR_W = 3
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic [7:0]         port_strobe,
    input  wire logic [7:0][7:0]    port_data_in,
    output logic      [7:0][7:0]    port_data_out,
    output logic      [7:0]         port_req_n,
    output logic                    irq,
    output logic      [2:0]         irq_code,
    input  wire logic               int_ack,
    input  wire logic               bus_input_strobe,
    input  wire logic               input_cycle_flag,
    input  wire logic               output_cycle_flag,
    input  wire logic [ADDR_W-1:0]  port_addr,
    input  wire logic [7:0]         cpu_data_in,
    output logic      [7:0]         cpu_data_out,
    output logic                    cpu_data_oe,
    input  wire logic [7:0]         buf_data_in,
    output logic      [7:0]         buf_data_out,
    output logic                    buf_data_oe
);
    // =====================================================
    // helpers
    // one-of-eight decode with active-low outputs; wider addressing is decoded outside
    function automatic logic [7:0] sel_n_of(input logic [ADDR_W-1:0] a);
        logic [7:0] r;
        r = 8'hff;
        // compare at int width: an 8 cast down to a 3-bit address would wrap to 0
        if (int'(a) < 8) begin
            r[a[2:0]] = 1'b0;
        end
        return r;
    endfunction

    // =====================================================
    // pin synchronisers
    logic [7:0] strobe_s1;
    logic [7:0] strobe_s2;
    always_ff @(posedge mclk) begin
        strobe_s1 <= port_strobe;
        strobe_s2 <= strobe_s1;
    end

    // =====================================================
    // state
    vio_pkg::vio_state_t st;
    vio_pkg::vio_state_t next_st;
    logic [7:0] sel_n;
    logic [7:0] req;
    logic [2:0] win;
    logic       any_req;
    logic       rd_io;
    logic       ack_cycle;

    always_comb begin
        next_st   = st;
        sel_n     = sel_n_of(port_addr);
        rd_io     = input_cycle_flag & ~int_ack;
        ack_cycle = int_ack;
        next_st.strobe_prev = strobe_s2;
        for (int i = 0; i < 8; i++) begin
            // latch follows strobe while high; byte held after it drops
            if (strobe_s2[i]) begin
                next_st.in_latch[i] = port_data_in[i];
            end
            // a select during an input cycle reads the port and withdraws its request
            if (!sel_n[i] && rd_io && bus_input_strobe) begin
                next_st.service_request_ff[i] = 1'b1;
            end else if (st.strobe_prev[i] && !strobe_s2[i]) begin
                next_st.service_request_ff[i] = 1'b0;
            end
            if (!sel_n[i] && output_cycle_flag) begin
                next_st.out_latch[i] = buf_data_in;
            end
        end
        for (int i = 0; i < 8; i++) begin
            req[i] = ~next_st.service_request_ff[i] & ~(!sel_n[i] && rd_io);
        end
        next_st.req_n = ~req;
        any_req = |req;
        win = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                win = 3'(i);
            end
        end
        // code frozen during acknowledge so the opcode cannot change mid-fetch
        if (!ack_cycle) begin
            next_st.code = win;
        end
        next_st.irq = any_req;
        // bus direction follows the bus-input strobe
        next_st.bus_to_cpu_oe = bus_input_strobe;
        next_st.bus_to_dev_oe = ~bus_input_strobe;
        next_st.bus_to_dev    = cpu_data_in;
        next_st.bus_to_cpu    = 8'h00;
        if (bus_input_strobe) begin
            if (ack_cycle) begin
                next_st.bus_to_cpu = `VIO_RST_OPCODE
                    | {2'h0, next_st.code, 3'h0};
            end else if (rd_io) begin
                for (int i = 0; i < 8; i++) begin
                    if (!sel_n[i]) begin
                        next_st.bus_to_cpu = st.in_latch[i];
                    end
                end
            end
        end
        if (srst) begin
            for (int i = 0; i < 8; i++) begin
                next_st.in_latch[i]  = `VIO_RST_BYTE;
                next_st.out_latch[i] = `VIO_RST_BYTE;
            end
            next_st.service_request_ff = {8{`VIO_RST_SR}};
            next_st.strobe_prev   = 8'h00;
            next_st.code          = 3'h0;
            next_st.irq           = 1'b0;
            next_st.req_n         = 8'hff;
            next_st.bus_to_cpu    = 8'h00;
            next_st.bus_to_cpu_oe = 1'b0;
            next_st.bus_to_dev    = 8'h00;
            next_st.bus_to_dev_oe = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    // =====================================================
    // outputs straight from the state register
    assign port_data_out = st.out_latch;
    assign port_req_n    = st.req_n;
    assign irq           = st.irq;
    assign irq_code      = st.code;
    assign cpu_data_out  = st.bus_to_cpu;
    assign cpu_data_oe   = st.bus_to_cpu_oe;
    assign buf_data_out  = st.bus_to_dev;
    assign buf_data_oe   = st.bus_to_dev_oe;
endmodule

// ===== src/vio_consts.svh
// constants of the vectored i/o port subsystem
// What this block does
// - eight byte-wide input ports and eight output ports share one buffered bus.
// - all port requests feed an eight-level encoder driving one positive interrupt.
// - the encoder gives a three-bit code of the winning port for the restart opcode.
// - on interrupt acknowledge the restart opcode with that code goes onto the bus.
// - the restart opcode reaches the processor only while the bus-input strobe is high.
// - the port address goes through a one-of-eight decoder with active-low selects.
// - the addressed input port drives the bus only while the bus-input strobe is high.
// - the bus driver goes processor-to-buffered with strobe low, reversed with it high.
// - an output port latches the bus byte when selected during an output cycle.
// - the decode covers eight ports only; a port address of 8 or more selects no port.
// - a port's request flip-flop clears on the strobe's falling edge only.
// - selecting a port in an input cycle with the bus-input strobe high sets its request flip-flop, withdrawing its request.
// - port request is active low: flip-flop cleared and port not selected in an input cycle.
`ifndef VIO_CONSTS_SVH
`define VIO_CONSTS_SVH
`define VIO_RST_BYTE    8'h00
`define VIO_RST_SR      1'b1
`define VIO_RST_OPCODE  8'hc7
`define VIO_CODE_LSB    3
`endif

// ===== src/vio_pkg.sv
// types of the vectored i/o port subsystem
package vio_pkg;
    typedef struct packed {
        logic [7:0][7:0] in_latch;
        logic [7:0][7:0] out_latch;
        logic [7:0]      service_request_ff;
        logic [7:0]      strobe_prev;
        logic [2:0]      code;
        logic            irq;
        logic [7:0]      bus_to_cpu;
        logic            bus_to_cpu_oe;
        logic [7:0]      bus_to_dev;
        logic            bus_to_dev_oe;
        logic [7:0]      req_n;
    } vio_state_t;
endpackage

// ===== bench/vio_port_subsystem_sva.sv
// assertion checker of the vectored i/o port subsystem
`include "vio_consts.svh"
module vio_port_subsystem_sva #(parameter int ADDR_W = 3) (
    input wire logic [7:0][7:0]   port_data_out,
    input wire logic [7:0]        port_strobe, port_req_n, cpu_data_in, cpu_data_out,
    input wire logic [7:0]        buf_data_in, buf_data_out,
    input wire logic [2:0]        irq_code,
    input wire logic [ADDR_W-1:0] port_addr,
    input wire logic              mclk, srst, irq, int_ack, bus_input_strobe,
    input wire logic              input_cycle_flag, output_cycle_flag, cpu_data_oe, buf_data_oe
);
    // ========
    // port checks
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire rd = input_cycle_flag & bus_input_strobe & ~int_ack;
    a_reset_idle: assert property ($fell(srst) |-> &port_req_n && !irq) else $error("busy");
    a_irq_any: assert property (!irq |-> &port_req_n) else $error("no irq");
    a_code_hold: assert property (int_ack && $past(int_ack) |-> $stable(irq_code))
        else $error("code moved");
    a_ack_opcode: assert property (int_ack && bus_input_strobe |=> cpu_data_oe &&
        cpu_data_out == (`VIO_RST_OPCODE | {$past(irq_code), 3'h0})) else $error("restart");
    a_dir_in: assert property (bus_input_strobe |=> cpu_data_oe && !buf_data_oe)
        else $error("dir in");
    a_dir_out: assert property (!bus_input_strobe |=> buf_data_oe &&
        buf_data_out == $past(cpu_data_in)) else $error("dir out");
    a_read_sets: assert property (rd |=> port_req_n[$past(port_addr)]) else $error("kept");
    a_out_latch: assert property (output_cycle_flag |=>
        port_data_out[$past(port_addr)] == $past(buf_data_in)) else $error("no write");
    a_out_hold: assert property (!output_cycle_flag |=> $stable(port_data_out))
        else $error("stray write");
    for (genvar i = 0; i < 8; i++) begin : g_fall
        a_fall_only: assert property ($fell(port_req_n[i]) |-> !$past(port_strobe[i], 2) &&
            ($past(port_strobe[i], 4) || $past(port_strobe[i], 5))) else $error("no fall");
    end
    c_ack: cover property (int_ack && bus_input_strobe);
    c_read: cover property (rd && !port_req_n[port_addr]);
    c_write: cover property (output_cycle_flag);
endmodule
bind vio_port_subsystem vio_port_subsystem_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ===== bench/vio_periph.sv
// peripheral model: strobes a byte into each input port on command
module vio_periph (
    input  wire logic [7:0]      fire,
    input  wire logic [7:0]      fire_byte,
    input  wire logic            mclk,
    output logic      [7:0]      port_strobe = '0,
    output logic      [7:0][7:0] port_data_in = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [8];
    always @(posedge mclk) begin
        for (int i = 0; i < 8; i++) begin
            if (fire[i]) begin
                cnt[i] = 7;
                port_data_in[i] <= fire_byte;
            end else if (cnt[i] > 0) cnt[i]--;
            else port_data_in[i] <= ~port_data_in[i]; // hold over: no stale byte
            port_strobe[i] <= cnt[i] > 4;
        end
    end
endmodule

// ===== bench/vio_port_subsystem_tb_top.sv
// self-checking bench of the vectored i/o port subsystem
`include "vio_consts.svh"
module vio_port_subsystem_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic            mclk = 0, srst = 1, int_ack = 0, bus_input_strobe = 0, irq, cpu_data_oe;
    logic            input_cycle_flag = 0, output_cycle_flag = 0, buf_data_oe;
    logic [7:0]      fire = 0, fire_byte = 0, cpu_data_in = 0, buf_data_in = 0, pend;
    logic [7:0]      port_strobe, port_req_n, cpu_data_out, buf_data_out, exp_b [8];
    logic [2:0]      port_addr = 0, irq_code;
    logic [7:0][7:0] port_data_in, port_data_out;
    int              n_mismatch = 0, samples_checked = 0, cyc = 0;
    vio_port_subsystem dut (.*);
    vio_periph u_per (.*);
    always #5 mclk = ~mclk;
    // ========
    // checking
    always @(posedge mclk) if (++cyc == 3000) begin n_mismatch++; final_report; end
    task automatic tick(int n); repeat (n) @(negedge mclk); endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] low(logic [7:0] p);
        low = 0;
        for (int i = 7; i >= 0; i--) if (p[i]) low = i;
    endfunction
    task automatic final_report;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hd50e5d40));
        tick(20);
        srst = 0;
        tick(2);
        chk(port_req_n, 8'hff);
        for (int t = 0; t < 4; t++) begin
            pend = 8'($urandom) | 8'h80;
            for (int i = 0; i < 8; i++) begin
                fire = 8'(pend[i]) << i;
                fire_byte = 8'($urandom);
                if (pend[i]) exp_b[i] = fire_byte;
                tick(1);
            end
            fire = 0;
            tick(12);
            chk(port_req_n, ~pend);
            while (pend != 0) begin
                chk({7'h0, irq}, 8'h01);
                chk({5'h0, irq_code}, low(pend));
                {int_ack, bus_input_strobe} = 2'b11;
                tick(2);
                chk(cpu_data_out, `VIO_RST_OPCODE | (low(pend) << `VIO_CODE_LSB));
                {int_ack, input_cycle_flag, port_addr} = {2'b01, 3'(low(pend))};
                tick(1);
                chk(cpu_data_out, exp_b[port_addr]);
                pend[port_addr] = 0;
                {input_cycle_flag, bus_input_strobe} = 2'b00;
                tick(1);
                chk(port_req_n, ~pend);
            end
            for (int i = 0; i < 8; i++) begin
                {output_cycle_flag, port_addr, buf_data_in, cpu_data_in} = {4'(8 + i), 16'($urandom)};
                tick(1);
                chk(port_data_out[i], buf_data_in);
                chk(buf_data_out, cpu_data_in);
            end
            output_cycle_flag = 0;
            $display("test %0d done", t);
        end
        final_report;
    end
endmodule
